// ---- logic/rifc_pkg.sv ----
// constants, types and register map of the reader irq/fifo/command core
// assumes a 40 MHz system clock and a serial link sampled from pins
// ----------------------------------------------------------------------------
// Overview of operation
// - an interrupt event sets its status bit and raises the request pin
// - reading interrupt status clears all bits but those set in the clearing cycle, then drops the request pin if no unmasked bit is left
// - masked sources still set status but never raise the request pin
// - clear after read by oscillator tick, or first serial clock rise in target state
// - a 32-byte FIFO holds transmit bytes and received bytes
// - transmit water interrupt when bytes left fall below the level
// - receive water interrupt when bytes held exceed the receive level
// - one config bit for each direction picks one of two levels
// - FIFO status shows the count of bytes not yet read
// - receive write into a full FIFO sets overflow and drops the byte
// - set-default returns every register to reset value in any mode
// - clear aborts activity, empties FIFO, clears collision and interrupt state
// - transmit commands except the NFC ones accepted only while transmitter enable is set
// - NFC transmit first checks field against threshold; response n random 0 to 3
// - a detected collision skips sending and raises the NFC event
// - field held 65 us after NFC send, then off with end-of-transmit event
// - NFC transmit needs peer mode and running oscillator
// - mask-receive forces receive-active low and stops receive framing
// - unmask-receive drives receive-active high and restarts framing
// - mask and unmask accepted only while receiver enable is set
// - A/D convert stores the analog pin result within 42 us, oscillator needed
// - measure-RF converts amplitude in absolute mode; full scale gives E6
// - a command byte is mode bits 11 then six code bits, MSB first
// - command runs on the falling edge of its last serial clock
// ----------------------------------------------------------------------------
package rifc_pkg;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          CNT_W         = 6;
  localparam int          CLK_MHZ       = 40;
  localparam int          FIELD_HOLD_US = 65;
  localparam int          FIELD_HOLD_CYC = FIELD_HOLD_US * CLK_MHZ;
  localparam int          ADC_TIME_US   = 42;
  localparam int          ADC_CYC       = ADC_TIME_US * CLK_MHZ;
  localparam int          CA_SLOT_CYC   = 8;
  // register index map
  localparam logic [5:0]  A_CTRL        = 6'h00;
  localparam logic [5:0]  A_CFG         = 6'h01;
  localparam logic [5:0]  A_IMASK       = 6'h02;
  localparam logic [5:0]  A_ISTAT       = 6'h03;
  localparam logic [5:0]  A_FSTAT       = 6'h04;
  localparam logic [5:0]  A_ADC         = 6'h05;
  localparam logic [5:0]  A_THR         = 6'h06;
  localparam logic [5:0]  A_COLL        = 6'h07;
  localparam logic [5:0]  A_STATE       = 6'h08;
  // interrupt bit positions
  localparam int          I_WATER = 0;
  localparam int          I_EOT   = 1;
  localparam int          I_EOR   = 2;
  localparam int          I_NFC   = 3;
  localparam int          I_ADC   = 4;
  localparam int          I_COLL  = 5;
  localparam int          I_OVF   = 6;
  localparam int          N_IRQ   = 7;
  // control bits
  localparam int          C_TX_EN  = 0;
  localparam int          C_RX_EN  = 1;
  localparam int          C_OSC_OK = 2;
  localparam int          C_NFC    = 3;
  localparam int          C_TGT    = 4;
  localparam int          CFG_RXW  = 0;
  localparam int          CFG_TXW  = 1;
  localparam logic [5:0]  RX_WL_LO = 6'h10;
  localparam logic [5:0]  RX_WL_HI = 6'h18;
  localparam logic [5:0]  TX_WL_LO = 6'h08;
  localparam logic [5:0]  TX_WL_HI = 6'h10;
  localparam logic [7:0]  ADC_FULL = 8'hE6;
  localparam logic [1:0]  MODE_CMD = 2'h3;
  // command codes
  localparam logic [5:0]  K_DEFAULT = 6'h01;
  localparam logic [5:0]  K_CLEAR   = 6'h02;
  localparam logic [5:0]  K_TX_CRC  = 6'h04;
  localparam logic [5:0]  K_TX_NCRC = 6'h05;
  localparam logic [5:0]  K_REQA    = 6'h06;
  localparam logic [5:0]  K_WUPA    = 6'h07;
  localparam logic [5:0]  K_NFC_INI = 6'h08;
  localparam logic [5:0]  K_NFC_RSP = 6'h09;
  localparam logic [5:0]  K_NFC_R0  = 6'h0A;
  localparam logic [5:0]  K_RX_MASK = 6'h10;
  localparam logic [5:0]  K_RX_UNM  = 6'h11;
  localparam logic [5:0]  K_ADC     = 6'h13;
  localparam logic [5:0]  K_RF_MEAS = 6'h14;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rifc_bus_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rifc_byte_t;
endpackage

// ---- logic/rifc_core.sv ----
// reader irq, FIFO and direct command core
// assumes the serial framer feeds register strobes on CLK; serial pins are raw
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
module rifc_core #(
  parameter int FIELD_HOLD = rifc_pkg::FIELD_HOLD_CYC,
  parameter int ADC_TIME   = rifc_pkg::ADC_CYC
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire rifc_pkg::rifc_bus_t BUS,
  output logic [7:0]             RDATA,
  input  wire rifc_pkg::rifc_byte_t TXF_IN,
  input  wire logic              TXF_TAKE,
  output rifc_pkg::rifc_byte_t   TXF_OUT,
  input  wire rifc_pkg::rifc_byte_t RXF_IN,
  input  wire logic              SCLK,
  input  wire logic              SDATAI,
  input  wire logic              SERIAL_SELECT,
  input  wire logic              OSC_TICK,
  input  wire logic              TX_DONE,
  input  wire logic              RX_DONE,
  input  wire logic              RF_FIELD_SEEN,
  input  wire logic [7:0]        ADC_SAMPLE,
  output logic                   IRQ_REQUEST_PIN,
  output logic                   RX_ACTIVE,
  output logic                   TX_START,
  output logic                   FIELD_ON,
  output logic                   ADC_ABS_MODE
);
  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] sclk_s_q, sdi_s_q, sel_s_q;
  logic       sclk_d1_q;
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      sclk_s_q  <= 2'h0;
      sdi_s_q   <= 2'h0;
      sel_s_q   <= 2'h0;
      sclk_d1_q <= 1'b0;
    end
    else
    begin
      sclk_s_q  <= {sclk_s_q[0], SCLK};
      sdi_s_q   <= {sdi_s_q[0], SDATAI};
      sel_s_q   <= {sel_s_q[0], SERIAL_SELECT};
      sclk_d1_q <= sclk_s_q[1];
    end
  end
  wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_d1_q;

  // ----------------------------------------------------------------------------
  // command byte capture, sampled on falling serial clock
  // ----------------------------------------------------------------------------
  logic [7:0] sh_q;
  logic [3:0] bit_cnt_q;
  logic       first_q;
  logic       cmd_v_q;
  logic [5:0] cmd_q;
  always_ff @(posedge CLK)
  begin
    if (!RST_B || !sel_s_q[1])
    begin
      sh_q      <= 8'h00;
      bit_cnt_q <= 4'h0;
      first_q   <= 1'b1;
      cmd_v_q   <= 1'b0;
      cmd_q     <= 6'h00;
    end
    else
    begin
      cmd_v_q <= 1'b0;
      if (sclk_fall && first_q)
      begin
        sh_q      <= {sh_q[6:0], sdi_s_q[1]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'h7)
        begin
          first_q <= 1'b0;
          // only the first byte after select carries the mode
          if (sh_q[6:5] == rifc_pkg::MODE_CMD)
          begin
            cmd_v_q <= 1'b1;
            cmd_q   <= {sh_q[4:0], sdi_s_q[1]};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [7:0] ctrl_q, cfg_q, imask_q, thr_q, coll_q, adc_q;
  logic [rifc_pkg::N_IRQ-1:0] istat_q;
  logic       ovf_q;
  logic       clr_pend_q;
  logic       do_default, do_clear;
  logic [rifc_pkg::N_IRQ-1:0] ev;
  logic       tx_ok, rx_ok, osc_ok, nfc_ok;
  assign tx_ok  = ctrl_q[rifc_pkg::C_TX_EN];
  assign rx_ok  = ctrl_q[rifc_pkg::C_RX_EN];
  assign osc_ok = ctrl_q[rifc_pkg::C_OSC_OK];
  assign nfc_ok = ctrl_q[rifc_pkg::C_NFC] & osc_ok;
  assign do_default = cmd_v_q && cmd_q == rifc_pkg::K_DEFAULT;
  assign do_clear   = cmd_v_q && cmd_q == rifc_pkg::K_CLEAR;

  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default)
    begin
      ctrl_q  <= 8'h00;
      cfg_q   <= 8'h00;
      imask_q <= 8'h00;
      thr_q   <= 8'h00;
    end
    else if (BUS.wr)
    begin
      unique case (BUS.addr)
        rifc_pkg::A_CTRL:  ctrl_q  <= BUS.wdata;
        rifc_pkg::A_CFG:   cfg_q   <= BUS.wdata;
        rifc_pkg::A_IMASK: imask_q <= BUS.wdata;
        rifc_pkg::A_THR:   thr_q   <= BUS.wdata;
        default:           ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // interrupt status: set wins over the deferred clear
  wire clr_now = clr_pend_q &&
                 (ctrl_q[rifc_pkg::C_TGT] ? sclk_rise : OSC_TICK);
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default || do_clear)
      clr_pend_q <= 1'b0;
    else if (BUS.rd && BUS.addr == rifc_pkg::A_ISTAT)
      clr_pend_q <= 1'b1;
    else if (clr_now)
      clr_pend_q <= 1'b0;
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default || do_clear)
      istat_q <= '0;
    else if (clr_now)
      istat_q <= ev;
    else
      istat_q <= istat_q | ev;
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      IRQ_REQUEST_PIN <= 1'b0;
    else
      IRQ_REQUEST_PIN <= |(istat_q & ~imask_q[rifc_pkg::N_IRQ-1:0]);
  end

  // ----------------------------------------------------------------------------
  // FIFO shared by both directions
  // ----------------------------------------------------------------------------
  logic [7:0]             mem [rifc_pkg::FIFO_DEPTH];
  logic [4:0]             wp_q, rp_q;
  logic [rifc_pkg::CNT_W-1:0] cnt_q;
  logic                   rx_mode_q;
  wire full  = cnt_q == rifc_pkg::CNT_W'(rifc_pkg::FIFO_DEPTH);
  wire rx_wr = RXF_IN.valid && RX_ACTIVE;
  wire wr_en = (TXF_IN.valid || rx_wr) && !full;
  wire rd_en = TXF_TAKE && cnt_q != '0;
  always_ff @(posedge CLK)
  begin
    if (wr_en)
      mem[wp_q] <= TXF_IN.valid ? TXF_IN.data : RXF_IN.data;
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default || do_clear)
    begin
      wp_q    <= 5'h00;
      rp_q    <= 5'h00;
      cnt_q   <= '0;
      TXF_OUT <= '0;
    end
    else
    begin
      if (wr_en)
        wp_q <= wp_q + 5'h01;
      if (rd_en)
        rp_q <= rp_q + 5'h01;
      cnt_q   <= cnt_q + (wr_en ? 6'h01 : 6'h00) - (rd_en ? 6'h01 : 6'h00);
      TXF_OUT <= '{valid: rd_en, data: mem[rp_q]};
    end
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default || do_clear)
      ovf_q <= 1'b0;
    else if (rx_wr && full)
      ovf_q <= 1'b1;
  end

  // water level, edge sensitive so one crossing gives one event
  logic [5:0] rx_wl, tx_wl;
  logic       water_q;
  assign rx_wl = cfg_q[rifc_pkg::CFG_RXW] ? rifc_pkg::RX_WL_HI : rifc_pkg::RX_WL_LO;
  assign tx_wl = cfg_q[rifc_pkg::CFG_TXW] ? rifc_pkg::TX_WL_HI : rifc_pkg::TX_WL_LO;
  logic       water;
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      water_q <= 1'b0;
    else
      water_q <= water;
  end

  // ----------------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_CA, S_SEND, S_HOLD, S_ADC} rifc_st_t;
  rifc_st_t   st_q;
  logic [15:0] tmr_q;
  logic [1:0]  lfsr_n_q;
  logic [7:0]  lfsr_q;
  logic        meas_rf_q;
  logic        tx_busy;
  assign tx_busy = st_q == S_SEND;
  // transmit level only counts while bytes are leaving, receive level after the send
  assign water   = rx_mode_q ? (cnt_q > rx_wl) : (tx_busy && cnt_q < tx_wl);
  wire is_tx  = cmd_q inside {rifc_pkg::K_TX_CRC, rifc_pkg::K_TX_NCRC, rifc_pkg::K_REQA, rifc_pkg::K_WUPA};
  wire is_nfc = cmd_q inside {rifc_pkg::K_NFC_INI, rifc_pkg::K_NFC_RSP, rifc_pkg::K_NFC_R0};
  wire is_adc = cmd_q inside {rifc_pkg::K_ADC, rifc_pkg::K_RF_MEAS};
  wire go_tx  = cmd_v_q && is_tx && tx_ok && st_q == S_IDLE;
  wire go_nfc = cmd_v_q && is_nfc && nfc_ok && st_q == S_IDLE;
  wire go_adc = cmd_v_q && is_adc && osc_ok && st_q == S_IDLE;
  wire ca_hit = st_q == S_CA && RF_FIELD_SEEN && ADC_SAMPLE > thr_q;

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      lfsr_q <= 8'h01;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default || do_clear)
    begin
      st_q      <= S_IDLE;
      tmr_q     <= 16'h0000;
      TX_START  <= 1'b0;
      FIELD_ON  <= 1'b0;
      rx_mode_q <= 1'b0;
      lfsr_n_q  <= 2'h0;
      meas_rf_q <= 1'b0;
    end
    else
    begin
      TX_START <= 1'b0;
      unique case (st_q)
        S_IDLE:
        begin
          if (go_tx)
          begin
            st_q      <= S_SEND;
            TX_START  <= 1'b1;
            rx_mode_q <= 1'b0;
          end
          else if (go_nfc)
          begin
            st_q     <= S_CA;
            lfsr_n_q <= (cmd_q == rifc_pkg::K_NFC_RSP) ? lfsr_q[1:0] : 2'h0;
            tmr_q    <= 16'h0000;
          end
          else if (go_adc)
          begin
            st_q      <= S_ADC;
            meas_rf_q <= cmd_q == rifc_pkg::K_RF_MEAS;
            tmr_q     <= 16'h0000;
          end
          else if (RX_DONE)
            rx_mode_q <= 1'b0;
        end
        S_CA:
        begin
          tmr_q <= tmr_q + 16'h0001;
          if (ca_hit)
            st_q <= S_IDLE;
          else if (tmr_q == 16'(rifc_pkg::CA_SLOT_CYC * (lfsr_n_q + 1)))
          begin
            st_q     <= S_SEND;
            FIELD_ON <= 1'b1;
            TX_START <= 1'b1;
          end
        end
        S_SEND:
        begin
          if (TX_DONE)
          begin
            rx_mode_q <= 1'b1;
            tmr_q     <= 16'h0000;
            st_q      <= FIELD_ON ? S_HOLD : S_IDLE;
          end
        end
        S_HOLD:
        begin
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'(FIELD_HOLD - 1))
          begin
            FIELD_ON <= 1'b0;
            st_q     <= S_IDLE;
          end
        end
        S_ADC:
        begin
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'(ADC_TIME - 1))
            st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default)
      ADC_ABS_MODE <= 1'b0;
    else
      ADC_ABS_MODE <= (st_q == S_ADC) && meas_rf_q;
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default)
      adc_q <= 8'h00;
    else if (st_q == S_ADC && tmr_q == 16'(ADC_TIME - 1))
      adc_q <= ADC_SAMPLE;
  end
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default || do_clear)
      coll_q <= 8'h00;
    else if (ca_hit)
      coll_q <= coll_q + 8'h01;
  end
  // receive path gate
  always_ff @(posedge CLK)
  begin
    if (!RST_B || do_default)
      RX_ACTIVE <= 1'b1;
    else if (cmd_v_q && rx_ok && cmd_q == rifc_pkg::K_RX_MASK)
      RX_ACTIVE <= 1'b0;
    else if (cmd_v_q && rx_ok && cmd_q == rifc_pkg::K_RX_UNM)
      RX_ACTIVE <= 1'b1;
  end

  // event vector
  always_comb
  begin
    ev                  = '0;
    ev[rifc_pkg::I_WATER] = water && !water_q;
    ev[rifc_pkg::I_EOT]   = (st_q == S_SEND && TX_DONE && !FIELD_ON) ||
                            (st_q == S_HOLD && tmr_q == 16'(FIELD_HOLD - 1));
    ev[rifc_pkg::I_EOR]   = RX_DONE;
    ev[rifc_pkg::I_NFC]   = ca_hit;
    ev[rifc_pkg::I_ADC]   = st_q == S_ADC && tmr_q == 16'(ADC_TIME - 1);
    ev[rifc_pkg::I_COLL]  = ca_hit;
    ev[rifc_pkg::I_OVF]   = rx_wr && full && !ovf_q;
  end

  // ----------------------------------------------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      RDATA <= 8'h00;
    else if (BUS.rd)
    begin
      unique case (BUS.addr)
        rifc_pkg::A_CTRL:  RDATA <= ctrl_q;
        rifc_pkg::A_CFG:   RDATA <= cfg_q;
        rifc_pkg::A_IMASK: RDATA <= imask_q;
        rifc_pkg::A_ISTAT: RDATA <= {1'b0, istat_q};
        rifc_pkg::A_FSTAT: RDATA <= {ovf_q, 1'b0, cnt_q};
        rifc_pkg::A_ADC:   RDATA <= adc_q;
        rifc_pkg::A_THR:   RDATA <= thr_q;
        rifc_pkg::A_COLL:  RDATA <= coll_q;
        rifc_pkg::A_STATE: RDATA <= {5'h00, RX_ACTIVE, FIELD_ON, rx_mode_q};
        default:           RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  AST_IRQ_LEVEL: assert property (@(posedge CLK) disable iff (!RST_B)
    IRQ_REQUEST_PIN == |($past(istat_q) & ~$past(imask_q[rifc_pkg::N_IRQ-1:0])))
    else $error("request pin disagrees with unmasked status");
  AST_SET_STICKY: assert property (@(posedge CLK) disable iff (!RST_B)
    ev[rifc_pkg::I_EOR] && !do_clear && !do_default |=> istat_q[rifc_pkg::I_EOR])
    else $error("event did not set status");
  AST_CLEAR_AFTER_READ: assert property (@(posedge CLK) disable iff (!RST_B)
    clr_now && ev == '0 |=> istat_q == '0)
    else $error("status not cleared after read");
  AST_TX_GATE: assert property (@(posedge CLK) disable iff (!RST_B)
    cmd_v_q && is_tx && !tx_ok |=> !TX_START)
    else $error("transmit accepted while transmitter disabled");
  AST_OVF: assert property (@(posedge CLK) disable iff (!RST_B)
    rx_wr && full && !do_clear && !do_default |=>
      ovf_q && cnt_q == $past(cnt_q) - ($past(TXF_TAKE) ? 6'h01 : 6'h00))
    else $error("overflow not flagged");
  AST_HOLD_END: assert property (@(posedge CLK) disable iff (!RST_B)
    st_q == S_HOLD && tmr_q == 16'(FIELD_HOLD - 1) && !do_clear && !do_default |=>
      !FIELD_ON ##0 istat_q[rifc_pkg::I_EOT])
    else $error("field not dropped with end of transmit");
  AST_MASK_RX: assert property (@(posedge CLK) disable iff (!RST_B)
    cmd_v_q && rx_ok && cmd_q == rifc_pkg::K_RX_MASK |=> !RX_ACTIVE)
    else $error("receive not masked");
  AST_CLEAR_FIFO: assert property (@(posedge CLK) disable iff (!RST_B)
    do_clear |=> cnt_q == '0 && st_q == S_IDLE && istat_q == '0)
    else $error("clear left state behind");
endmodule

// ---- test/rifc_mcu.sv ----
// serial host model: sends direct command bytes over the 4-wire link
// assumes the core samples data on falling serial clock edges
`timescale 1ns/10ps
module rifc_mcu #(
  parameter int HALF_NS = 100
) (
  output logic sclk,
  output logic sdatai,
  output logic serial_select
);
  // ------------------------------
  // host frames
  // ------------------------------
  initial
  begin
    sclk = 1'b0;
    sdatai = 1'b0;
    serial_select = 1'b0;
  end
  // clock stands low between frames; a short frame gives spare clock edges
  task automatic frame(input logic [7:0] b, input int nbits);
    #7 serial_select = 1'b1;
    #(HALF_NS);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      sdatai = b[i];
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
      #(HALF_NS);
    end
    serial_select = 1'b0;
    sdatai = ~sdatai; // deselected line never keeps the last bit
  endtask
  task automatic send_cmd(input logic [5:0] code);
    frame({rifc_pkg::MODE_CMD, code}, 8);
  endtask
endmodule

// ---- test/test_reader_irq_fifo_command_core.sv ----
// self-checking bench of the reader irq, FIFO and direct command core
// assumes rifc_mcu as serial host; the core carries its own assertions
`timescale 1ns/10ps
module test_reader_irq_fifo_command_core;
  // ------------------------------
  // wiring
  // ------------------------------
  localparam int        HOLD = 20;
  localparam int        ADCT = 10;
  logic                 clk;
  logic                 rst_b;
  rifc_pkg::rifc_bus_t  bus;
  logic [7:0]           rdata;
  rifc_pkg::rifc_byte_t txf_in;
  logic                 txf_take;
  rifc_pkg::rifc_byte_t txf_out;
  rifc_pkg::rifc_byte_t rxf_in;
  logic                 sclk;
  logic                 sdatai;
  logic                 sel;
  logic                 osc_tick;
  logic                 tx_done;
  logic                 rx_done;
  logic                 rf_seen;
  logic [7:0]           adc_in;
  logic                 irq;
  logic                 rx_act;
  logic                 tx_start;
  logic                 field_on;
  logic                 abs_mode;
  logic [31:0]          seed;
  logic [7:0]           q[$];
  int                   err_count;
  int                   checked;
  int                   n_start;
  int                   n_abs;
  int                   exp_start;

  rifc_core #(
    .FIELD_HOLD (HOLD),
    .ADC_TIME   (ADCT)
  ) dut (
    .CLK             (clk),
    .RST_B           (rst_b),
    .BUS             (bus),
    .RDATA           (rdata),
    .TXF_IN          (txf_in),
    .TXF_TAKE        (txf_take),
    .TXF_OUT         (txf_out),
    .RXF_IN          (rxf_in),
    .SCLK            (sclk),
    .SDATAI          (sdatai),
    .SERIAL_SELECT   (sel),
    .OSC_TICK        (osc_tick),
    .TX_DONE         (tx_done),
    .RX_DONE         (rx_done),
    .RF_FIELD_SEEN   (rf_seen),
    .ADC_SAMPLE      (adc_in),
    .IRQ_REQUEST_PIN (irq),
    .RX_ACTIVE       (rx_act),
    .TX_START        (tx_start),
    .FIELD_ON        (field_on),
    .ADC_ABS_MODE    (abs_mode)
  );
  rifc_mcu mcu (
    .sclk          (sclk),
    .sdatai        (sdatai),
    .serial_select (sel)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // start pulses last one cycle, so count them instead of polling
  always @(posedge clk)
  begin
    if (tx_start === 1'b1) n_start++;
    if (abs_mode === 1'b1) n_abs++;
  end
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 chk(rdata, e);
  endtask
  // 0 oscillator tick, 1 transmit done, 2 receive done
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 1) tx_done <= 1'b1;
    else if (k == 2) rx_done <= 1'b1;
    else osc_tick <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    rx_done <= 1'b0;
    osc_tick <= 1'b0;
  endtask
  task automatic push(input bit rx, input int n);
    repeat (n)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      if (rx) rxf_in <= '{1'b1, seed[7:0]};
      else txf_in <= '{1'b1, seed[7:0]};
      if (!rx) q.push_back(seed[7:0]);
      @(posedge clk);
      rxf_in <= '0;
      txf_in <= '0;
    end
  endtask
  task automatic cmd(input logic [5:0] c);
    mcu.send_cmd(c);
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("errors %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  initial
  begin
    seed = 32'h07ED5FE4;
    {rst_b, txf_take, osc_tick, tx_done, rx_done, rf_seen, adc_in} = '0;
    {bus, txf_in, rxf_in} = '0;
    {err_count, checked, n_start, n_abs, exp_start} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rc(rifc_pkg::A_ISTAT, 8'h00);
    chk({irq, rx_act}, 8'h01);
    wr(6'h3F, 8'hFF);
    rc(6'h3F, 8'h00);
    // nothing enabled yet: every transmit, convert and mask must be dropped
    for (int k = 0; k < 7; k++) cmd(rifc_pkg::K_TX_CRC + 6'(k));
    cmd(rifc_pkg::K_ADC);
    cmd(rifc_pkg::K_RX_MASK);
    chk(n_start[7:0], 8'h00);
    rc(rifc_pkg::A_ISTAT, 8'h00);
    chk({7'h00, rx_act}, 8'h01);
    wr(rifc_pkg::A_CTRL, 8'h07);
    // the core stays busy until the framer reports the send done
    for (int k = 0; k < 4; k++)
    begin
      cmd(rifc_pkg::K_TX_CRC + 6'(k));
      pulse(1);
    end
    chk(n_start[7:0], 8'h04);
    rc(rifc_pkg::A_ISTAT, 8'h03);
    pulse(0);
    // masked conversion: status set, request pin quiet
    seed = lfsr(seed);
    adc_in <= seed[7:0];
    wr(rifc_pkg::A_IMASK, 8'h10);
    cmd(rifc_pkg::K_ADC);
    repeat (ADCT + 4) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rc(rifc_pkg::A_ADC, seed[7:0]);
    rc(rifc_pkg::A_ISTAT, 8'h10);
    pulse(0);
    rc(rifc_pkg::A_ISTAT, 8'h00);
    wr(rifc_pkg::A_IMASK, 8'h00);
    adc_in <= rifc_pkg::ADC_FULL;
    cmd(rifc_pkg::K_RF_MEAS);
    repeat (ADCT + 4) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, n_abs > 0}, 8'h01);
    rc(rifc_pkg::A_ADC, 8'hE6);
    rc(rifc_pkg::A_ISTAT, 8'h10);
    pulse(0);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    // target state: a serial clock rise, not the oscillator, clears status
    wr(rifc_pkg::A_CTRL, 8'h17);
    cmd(rifc_pkg::K_ADC);
    repeat (ADCT + 4) @(posedge clk);
    rc(rifc_pkg::A_ISTAT, 8'h10);
    mcu.frame(8'h00, 1);
    repeat (8) @(posedge clk);
    rc(rifc_pkg::A_ISTAT, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(rifc_pkg::A_CTRL, 8'h07);
    // full FIFO sent out in order; water event once fewer than 8 remain
    cmd(rifc_pkg::K_CLEAR);
    push(0, 32);
    rc(rifc_pkg::A_FSTAT, 8'h20);
    cmd(rifc_pkg::K_TX_CRC);
    repeat (32)
    begin
      @(posedge clk);
      txf_take <= 1'b1;
      @(posedge clk);
      txf_take <= 1'b0;
      #1 chk(txf_out.data, q.pop_front());
      chk({7'h00, txf_out.valid}, 8'h01);
    end
    rc(rifc_pkg::A_ISTAT, 8'h01);
    pulse(1);
    pulse(0);
    cmd(rifc_pkg::K_CLEAR);
    rc(rifc_pkg::A_FSTAT, 8'h00);
    rc(rifc_pkg::A_ISTAT, 8'h00);
    cmd(rifc_pkg::K_RX_MASK);
    chk({7'h00, rx_act}, 8'h00);
    push(1, 1);
    rc(rifc_pkg::A_FSTAT, 8'h00);
    cmd(rifc_pkg::K_RX_UNM);
    chk({7'h00, rx_act}, 8'h01);
    // an empty send puts the core in receive mode
    cmd(rifc_pkg::K_TX_CRC);
    pulse(1);
    rc(rifc_pkg::A_ISTAT, 8'h03);
    pulse(0);
    // high receive level 24: 20 bytes stay quiet, 33 overflow
    wr(rifc_pkg::A_CFG, 8'h01);
    push(1, 20);
    rc(rifc_pkg::A_ISTAT, 8'h00);
    push(1, 13);
    rc(rifc_pkg::A_FSTAT, 8'hA0);
    pulse(2);
    rc(rifc_pkg::A_ISTAT, 8'h45);
    pulse(0);
    // peer mode without transmitter enable, field above threshold
    wr(rifc_pkg::A_CTRL, 8'h0C);
    wr(rifc_pkg::A_THR, 8'h40);
    exp_start = n_start;
    rf_seen <= 1'b1;
    adc_in <= 8'h80;
    cmd(rifc_pkg::K_NFC_R0);
    repeat (40) @(posedge clk);
    chk(n_start[7:0], exp_start[7:0]);
    rc(rifc_pkg::A_ISTAT, 8'h28);
    rc(rifc_pkg::A_COLL, 8'h01);
    pulse(0);
    rf_seen <= 1'b0;
    // level between both water marks, so no water event mixes in
    cmd(rifc_pkg::K_CLEAR);
    rc(rifc_pkg::A_COLL, 8'h00);
    push(1, 16);
    for (int k = 0; k < 3; k++)
    begin
      cmd(rifc_pkg::K_NFC_INI + 6'(k));
      repeat (40) @(posedge clk);
      exp_start++;
      chk(n_start[7:0], exp_start[7:0]);
      pulse(1);
      repeat (5) @(posedge clk);
      chk({7'h00, field_on}, 8'h01);
      repeat (HOLD + 5) @(posedge clk);
      chk({7'h00, field_on}, 8'h00);
      rc(rifc_pkg::A_ISTAT, 8'h02);
      pulse(0);
    end
    wr(rifc_pkg::A_IMASK, 8'h5A);
    cmd(rifc_pkg::K_DEFAULT);
    rc(rifc_pkg::A_IMASK, 8'h00);
    rc(rifc_pkg::A_CTRL, 8'h00);
    chk({7'h00, rx_act}, 8'h01);
    print_verdict();
  end
  // about 30 serial commands of 2 us each; a wide margin cuts a hang short
  initial
  begin
    #500000;
    err_count++;
    print_verdict();
  end
endmodule
